// File: design/srs_pkg.sv
// constants, opcodes and states for the scratchpad register space
package srs_pkg;
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 8;
  localparam int          RAM_DEPTH     = 256;
  localparam int          SFR_COUNT     = 128;
  localparam int          RET_W         = 16;
  localparam logic [7:0]  STACK_TOP_POINTER_ADDR = 8'h81;
  localparam logic [7:0]  STACK_TOP_POINTER_RESET = 8'h07;
  localparam logic [7:0]  FLAG_AND_BANK_WORD_ADDR = 8'hD0;
  localparam int          BANK_LSB      = 3;
  localparam int          BANK_MSB      = 4;
  localparam logic [3:0]  BIT_RAM_NIB   = 4'h2;
  localparam logic [7:0]  BIT_RAM_FIRST = 8'h20;
  localparam logic [7:0]  BIT_RAM_LAST  = 8'h2F;
  localparam logic [7:0]  SFR_RESET     = 8'h00;

  typedef enum logic [3:0] {
    SRS_OP_NOP    = 4'b0000,
    SRS_OP_RD_DIR = 4'b0001,
    SRS_OP_WR_DIR = 4'b0010,
    SRS_OP_RD_IND = 4'b0011,
    SRS_OP_WR_IND = 4'b0100,
    SRS_OP_RD_BIT = 4'b0101,
    SRS_OP_WR_BIT = 4'b0110,
    SRS_OP_PUSH   = 4'b0111,
    SRS_OP_POP    = 4'b1000,
    SRS_OP_CALL   = 4'b1001,
    SRS_OP_RET    = 4'b1010,
    SRS_OP_RD_REG = 4'b1011,
    SRS_OP_WR_REG = 4'b1100
  } srs_op_t;

  typedef enum logic [1:0] {
    SRS_ST_IDLE    = 2'b00,
    SRS_ST_CALL_HI = 2'b01,
    SRS_ST_RET_LO  = 2'b10
  } srs_state_t;
endpackage

// File: design/srs_mem_if.sv
// carrier between the access logic and the scratchpad byte store
interface srs_mem_if;
  import srs_pkg::*;
  logic [ADDR_W-1:0] rd_a_addr;
  logic [DATA_W-1:0] rd_a_data;
  logic [ADDR_W-1:0] rd_b_addr;
  logic [DATA_W-1:0] rd_b_data;
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  modport store (input rd_a_addr, rd_b_addr, wr_en, wr_addr, wr_data, output rd_a_data, rd_b_data);
  modport user  (output rd_a_addr, rd_b_addr, wr_en, wr_addr, wr_data, input rd_a_data, rd_b_data);
endinterface

// File: design/srs_byte_store.sv
// 256-byte scratchpad store, two read ports and one write port
module srs_byte_store
  import srs_pkg::*;
(
  input wire logic clk,
  srs_mem_if.store mem
);
  logic [DATA_W-1:0] ram [RAM_DEPTH];

  // full 8-bit range, upper half reached only by indirect and stack paths
  assign mem.rd_a_data = ram[mem.rd_a_addr];
  assign mem.rd_b_data = ram[mem.rd_b_addr];

  always_ff @(posedge clk)
  begin
    if (mem.wr_en)
    begin
      ram[mem.wr_addr] <= mem.wr_data;
    end
  end
endmodule

// File: design/srs_regspace.sv
// scratchpad register space: scratchpad, special registers, banks and stack
module srs_regspace (
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire logic                    req_valid,
  input  wire srs_pkg::srs_op_t        req_op,
  input  wire logic [srs_pkg::ADDR_W-1:0] req_addr,
  input  wire logic [2:0]              req_slot,
  input  wire logic                    req_ptr_sel,
  input  wire logic [srs_pkg::DATA_W-1:0] req_wdata,
  input  wire logic                    req_wbit,
  input  wire logic [srs_pkg::RET_W-1:0] req_ret_addr,
  output logic                         req_ready,
  output logic                         rsp_ack,
  output logic [srs_pkg::DATA_W-1:0]   rsp_rdata,
  output logic                         rsp_rbit,
  output logic [srs_pkg::RET_W-1:0]    rsp_ret_addr,
  output logic [srs_pkg::ADDR_W-1:0]   stack_top_pointer,
  output logic [1:0]                   active_bank,
  output logic                         sfr_wr_strobe,
  output logic [srs_pkg::ADDR_W-1:0]   sfr_wr_addr,
  output logic [srs_pkg::DATA_W-1:0]   sfr_wr_data
);
  import srs_pkg::*;

  srs_mem_if mem ();

  srs_byte_store u_store (
    .clk (clk),
    .mem (mem)
  );

  srs_state_t        state_reg;
  srs_state_t        state_next;
  logic [7:0]        sp_reg;
  logic [7:0]        sp_next;
  logic [7:0]        sfr_mem [SFR_COUNT];
  logic [7:0]        ret_hold_reg;
  logic              ready_reg;
  logic              ack_reg;
  logic [7:0]        rdata_reg;
  logic              rbit_reg;
  logic [15:0]       ret_addr_reg;
  logic              sfr_wr_strobe_reg;
  logic [7:0]        sfr_wr_addr_reg;
  logic [7:0]        sfr_wr_data_reg;

  // request decode, one request per cycle while idle
  wire         take      = req_valid && ready_reg;
  wire         idle      = (state_reg == SRS_ST_IDLE);
  wire         op_rd_dir = take && (req_op == SRS_OP_RD_DIR);
  wire         op_wr_dir = take && (req_op == SRS_OP_WR_DIR);
  wire         op_rd_ind = take && (req_op == SRS_OP_RD_IND);
  wire         op_wr_ind = take && (req_op == SRS_OP_WR_IND);
  wire         op_rd_bit = take && (req_op == SRS_OP_RD_BIT);
  wire         op_wr_bit = take && (req_op == SRS_OP_WR_BIT);
  wire         op_push   = take && (req_op == SRS_OP_PUSH);
  wire         op_pop    = take && (req_op == SRS_OP_POP);
  wire         op_call   = take && (req_op == SRS_OP_CALL);
  wire         op_ret    = take && (req_op == SRS_OP_RET);
  wire         op_rd_reg = take && (req_op == SRS_OP_RD_REG);
  wire         op_wr_reg = take && (req_op == SRS_OP_WR_REG);
  wire         call_hi   = (state_reg == SRS_ST_CALL_HI);
  wire         ret_lo    = (state_reg == SRS_ST_RET_LO);
  wire         any_bit   = op_rd_bit || op_wr_bit;
  wire         any_ind   = op_rd_ind || op_wr_ind;
  wire         stack_rd  = op_pop || op_ret || ret_lo;

  // active bank from flag word bits 4:3
  wire [6:0]   psw_idx   = FLAG_AND_BANK_WORD_ADDR[6:0];
  wire [1:0]   bank      = sfr_mem[psw_idx][BANK_MSB:BANK_LSB];

  // slot n of bank b sits at byte 8b+n
  wire [7:0]   slot_addr = {3'b000, bank, req_slot};
  wire [7:0]   ptr_addr  = {3'b000, bank, 2'b00, req_ptr_sel};

  // bit address: below 80h into 20h..2Fh, else the aligned special register
  wire [7:0]   bit_byte  = req_addr[7] ? {req_addr[7:3], 3'b000} : {BIT_RAM_NIB, req_addr[6:3]};
  wire [7:0]   dir_addr  = any_bit ? bit_byte : req_addr;
  wire         dir_any   = op_rd_dir || op_wr_dir || any_bit;
  wire         is_sfr    = dir_any && dir_addr[7];
  wire         is_sp     = (dir_addr == STACK_TOP_POINTER_ADDR);
  wire [7:0]   sfr_rd    = is_sp ? sp_reg : sfr_mem[dir_addr[6:0]];
  wire [7:0]   sp_inc    = sp_reg + 8'h01;
  wire [7:0]   sp_dec    = sp_reg - 8'h01;

  // read port a: working slot or pointer slot; port b: target byte
  assign mem.rd_a_addr = any_ind ? ptr_addr : slot_addr;
  assign mem.rd_b_addr = any_ind ? mem.rd_a_data : (stack_rd ? sp_reg : dir_addr);

  wire [7:0]   byte_val  = is_sfr ? sfr_rd : mem.rd_b_data;
  wire         bit_val   = byte_val[req_addr[2:0]];
  wire [7:0]   bit_new;

  genvar gi;
  generate
    for (gi = 0; gi < DATA_W; gi++)
    begin : g_bit
      assign bit_new[gi] = (req_addr[2:0] == 3'(gi)) ? req_wbit : byte_val[gi];
    end
  endgenerate

  // scratchpad write selection
  wire         ram_dir_wr = (op_wr_dir || op_wr_bit) && !is_sfr;
  wire         push_wr    = op_push || op_call || call_hi;
  assign mem.wr_en   = ram_dir_wr || op_wr_ind || op_wr_reg || push_wr;
  assign mem.wr_addr = push_wr ? sp_inc :
                       op_wr_ind ? mem.rd_a_data :
                       op_wr_reg ? slot_addr : dir_addr;
  assign mem.wr_data = op_call ? req_ret_addr[7:0] :
                       call_hi ? ret_hold_reg :
                       op_wr_bit ? bit_new : req_wdata;

  // special register write
  wire         sfr_wr    = (op_wr_dir || op_wr_bit) && is_sfr;
  wire [7:0]   sfr_wdat  = op_wr_bit ? bit_new : req_wdata;
  wire         sfr_wr_sp = sfr_wr && is_sp;

  // stack pointer next value
  assign sp_next = sfr_wr_sp ? sfr_wdat :
                   push_wr ? sp_inc :
                   stack_rd ? sp_dec : sp_reg;

  // sequencer for two-byte call and return, unused code falls back to idle
  always_comb
  begin
    state_next = SRS_ST_IDLE;
    unique case (state_reg)
      SRS_ST_IDLE:
      begin
        if (op_call)
        begin
          state_next = SRS_ST_CALL_HI;
        end
        else if (op_ret)
        begin
          state_next = SRS_ST_RET_LO;
        end
      end
      SRS_ST_CALL_HI: state_next = SRS_ST_IDLE;
      SRS_ST_RET_LO:  state_next = SRS_ST_IDLE;
      default:        state_next = SRS_ST_IDLE;
    endcase
  end

  wire         done_rd   = op_rd_dir || op_rd_ind || op_rd_bit || op_pop || op_rd_reg;
  wire         ack_next  = take && !op_call && !op_ret || call_hi || ret_lo;
  wire [7:0]   rdata_next = op_rd_reg ? mem.rd_a_data :
                            (op_rd_ind || op_pop) ? mem.rd_b_data :
                            op_rd_bit ? rdata_reg : byte_val;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= SRS_ST_IDLE;
      ready_reg <= 1'b0;
      sp_reg    <= STACK_TOP_POINTER_RESET;
    end
    else
    begin
      state_reg <= state_next;
      ready_reg <= (state_next == SRS_ST_IDLE);
      sp_reg    <= sp_next;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < SFR_COUNT; i++)
      begin
        sfr_mem[i] <= SFR_RESET;
      end
    end
    else if (sfr_wr && !is_sp)
    begin
      sfr_mem[dir_addr[6:0]] <= sfr_wdat;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ret_hold_reg <= 8'h00;
      ack_reg      <= 1'b0;
      rdata_reg    <= 8'h00;
      rbit_reg     <= 1'b0;
      ret_addr_reg <= 16'h0000;
    end
    else
    begin
      ret_hold_reg <= op_call ? req_ret_addr[15:8] : (op_ret ? mem.rd_b_data : ret_hold_reg);
      ack_reg      <= ack_next;
      rdata_reg    <= done_rd ? rdata_next : rdata_reg;
      rbit_reg     <= op_rd_bit ? bit_val : rbit_reg;
      ret_addr_reg <= ret_lo ? {ret_hold_reg, mem.rd_b_data} : ret_addr_reg;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sfr_wr_strobe_reg <= 1'b0;
      sfr_wr_addr_reg   <= 8'h00;
      sfr_wr_data_reg   <= 8'h00;
    end
    else
    begin
      sfr_wr_strobe_reg <= sfr_wr;
      sfr_wr_addr_reg   <= sfr_wr ? dir_addr : sfr_wr_addr_reg;
      sfr_wr_data_reg   <= sfr_wr ? sfr_wdat : sfr_wr_data_reg;
    end
  end

  assign req_ready         = ready_reg;
  assign rsp_ack           = ack_reg;
  assign rsp_rdata         = rdata_reg;
  assign rsp_rbit          = rbit_reg;
  assign rsp_ret_addr      = ret_addr_reg;
  assign stack_top_pointer = sp_reg;
  assign active_bank       = bank;
  assign sfr_wr_strobe     = sfr_wr_strobe_reg;
  assign sfr_wr_addr       = sfr_wr_addr_reg;
  assign sfr_wr_data       = sfr_wr_data_reg;

  // checks
  sp_reset_val_a: assert property (@(posedge clk) $rose(nrst) |-> sp_reg == STACK_TOP_POINTER_RESET)
    else $error("stack pointer not at reset value after reset");

  push_inc_a: assert property (@(posedge clk) disable iff (!nrst)
    op_push |=> sp_reg == 8'($past(sp_reg) + 8'h01))
    else $error("push did not raise stack pointer by one");

  pop_dec_a: assert property (@(posedge clk) disable iff (!nrst)
    op_pop |=> sp_reg == 8'($past(sp_reg) - 8'h01))
    else $error("pop did not lower stack pointer by one");

  call_two_bytes_a: assert property (@(posedge clk) disable iff (!nrst)
    op_call |=> call_hi ##1 (sp_reg == 8'($past(sp_reg, 2) + 8'h02) && ack_reg))
    else $error("call did not store two bytes");

  ret_two_bytes_a: assert property (@(posedge clk) disable iff (!nrst)
    op_ret |=> ##1 (sp_reg == 8'($past(sp_reg, 2) - 8'h02) && ack_reg))
    else $error("return did not remove two bytes");

  push_target_a: assert property (@(posedge clk) disable iff (!nrst)
    push_wr |-> mem.wr_en && mem.wr_addr == 8'(sp_reg + 8'h01))
    else $error("stack write not at pointer plus one");

  direct_low_ram_a: assert property (@(posedge clk) disable iff (!nrst)
    op_wr_dir && !req_addr[7] |-> mem.wr_en && mem.wr_addr == req_addr)
    else $error("low direct write missed scratchpad");

  direct_high_sfr_a: assert property (@(posedge clk) disable iff (!nrst)
    op_wr_dir && req_addr[7] |-> !mem.wr_en ##1 sfr_wr_strobe_reg && sfr_wr_addr_reg == $past(req_addr))
    else $error("high direct write reached scratchpad");

  bank_slot_a: assert property (@(posedge clk) disable iff (!nrst)
    op_rd_reg |-> mem.rd_a_addr[4:3] == sfr_mem[psw_idx][4:3] && mem.rd_a_addr[7:5] == 3'b000)
    else $error("slot outside active bank");

  ind_ptr_a: assert property (@(posedge clk) disable iff (!nrst)
    op_rd_ind |-> mem.rd_b_addr == mem.rd_a_data ##1 rsp_ack)
    else $error("indirect address not taken from pointer slot");

  bit_ram_range_a: assert property (@(posedge clk) disable iff (!nrst)
    op_wr_bit && !req_addr[7] |-> mem.wr_addr >= BIT_RAM_FIRST && mem.wr_addr <= BIT_RAM_LAST)
    else $error("bit write outside bit region");

  bit_sfr_align_a: assert property (@(posedge clk) disable iff (!nrst)
    any_bit && req_addr[7] |-> is_sfr && dir_addr[2:0] == 3'b000)
    else $error("special register bit access not aligned");

  call_ret_gap_a: assert property (@(posedge clk) disable iff (!nrst)
    (op_call || op_ret) |=> (!ready_reg && !idle) ##1 (ready_reg && idle))
    else $error("call or return did not hold off the next request for one cycle");

  sp_direct_wr_a: assert property (@(posedge clk) disable iff (!nrst)
    (op_wr_dir && req_addr == STACK_TOP_POINTER_ADDR) |=> sp_reg == $past(req_wdata))
    else $error("direct write to stack pointer not loaded");

  ind_wr_ram_a: assert property (@(posedge clk) disable iff (!nrst)
    op_wr_ind |-> mem.wr_en && mem.wr_addr == mem.rd_a_data && !sfr_wr)
    else $error("indirect write missed scratchpad");

  stack_rd_src_a: assert property (@(posedge clk) disable iff (!nrst)
    stack_rd |-> mem.rd_b_addr == sp_reg)
    else $error("stack read not at pointer");

  call_low_first_a: assert property (@(posedge clk) disable iff (!nrst)
    op_call |-> mem.wr_en && mem.wr_data == req_ret_addr[7:0])
    else $error("call did not store low return byte first");

  sfr_notify_a: assert property (@(posedge clk) disable iff (!nrst)
    sfr_wr |=> sfr_wr_strobe_reg && sfr_wr_data_reg == $past(sfr_wdat))
    else $error("special register write not announced");

  ram_no_notify_a: assert property (@(posedge clk) disable iff (!nrst)
    ((op_wr_dir || op_wr_bit) && !dir_addr[7]) |=> !sfr_wr_strobe_reg)
    else $error("scratchpad write announced as special register write");

  store_wr_src_a: assert property (@(posedge clk) disable iff (!nrst)
    mem.wr_en |-> take || call_hi)
    else $error("scratchpad written without a request");
endmodule

// File: tb/srs_core_model.sv
// core-side requester model for the register space request port
module srs_core_model (
  input  wire logic                  clk,
  input  wire logic                  req_ready,
  input  wire logic                  rsp_ack,
  output logic                       req_valid,
  output srs_pkg::srs_op_t           req_op,
  output logic [srs_pkg::ADDR_W-1:0] req_addr,
  output logic [2:0]                 req_slot,
  output logic                       req_ptr_sel,
  output logic [srs_pkg::DATA_W-1:0] req_wdata,
  output logic                       req_wbit,
  output logic [srs_pkg::RET_W-1:0]  req_ret_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  import srs_pkg::*;
  int   idle = 0;
  int   lat;
  logic tmo = 1'b0;
  initial
  begin
    req_valid = 1'b0;
    req_op = SRS_OP_NOP;
    {req_addr, req_slot, req_ptr_sel, req_wdata, req_wbit, req_ret_addr} = '0;
  end
  // drops a standing request; address, write data and return address flip so a stale value never passes for a fresh one
  task automatic rest();
    if (req_valid)
    begin
      req_valid = 1'b0;
      req_op = SRS_OP_NOP;
      {req_addr, req_wdata, req_ret_addr} = ~{req_addr, req_wdata, req_ret_addr};
    end
  endtask
  // request held from a falling edge until the rising edge that takes it
  task automatic issue(input srs_op_t o, input logic [7:0] a, input logic [2:0] s, input logic p,
                       input logic [7:0] wd, input logic wb, input logic [15:0] ra);
    int n;
    n = 0;
    if (idle > 0)
    begin
      rest();
      repeat (idle) @(negedge clk);
    end
    req_valid = 1'b1;
    req_op = o;
    {req_addr, req_slot, req_ptr_sel, req_wdata, req_wbit, req_ret_addr} = {a, s, p, wd, wb, ra};
    while (req_ready !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    // a one-cycle answer stands at this falling edge; valid stays up for a back-to-back request
    lat = 1;
    while (rsp_ack !== 1'b1 && lat < 8)
    begin
      rest();
      @(negedge clk);
      lat++;
    end
    tmo = (n >= 20) || (rsp_ack !== 1'b1);
  endtask
endmodule

// File: tb/tb.sv
// self-checking bench for the scratchpad register space
`define chk(got, exp) \
  begin n_compared++; if ((got) !== (exp)) begin errors++; \
  $display("ERROR %0t got %h exp %h", $time, got, exp); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import srs_pkg::*;
  typedef struct {srs_op_t o; logic [7:0] a; logic [7:0] wd; int k; logic [7:0] e;} srs_row_t;
  srs_row_t     rows[$];
  int           errors = 0;
  int           n_compared = 0;
  logic         clk, nrst, req_valid, req_ptr_sel, req_wbit, req_ready, rsp_ack, rsp_rbit, sfr_wr_strobe;
  srs_op_t      req_op;
  logic [7:0]   req_addr, req_wdata, rsp_rdata, stack_top_pointer, sfr_wr_addr, sfr_wr_data;
  logic [2:0]   req_slot;
  logic [15:0]  req_ret_addr, rsp_ret_addr;
  logic [1:0]   active_bank;
  srs_regspace i_dut (.clk(clk), .nrst(nrst), .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr),
    .req_slot(req_slot), .req_ptr_sel(req_ptr_sel), .req_wdata(req_wdata), .req_wbit(req_wbit),
    .req_ret_addr(req_ret_addr), .req_ready(req_ready), .rsp_ack(rsp_ack), .rsp_rdata(rsp_rdata),
    .rsp_rbit(rsp_rbit), .rsp_ret_addr(rsp_ret_addr), .stack_top_pointer(stack_top_pointer),
    .active_bank(active_bank), .sfr_wr_strobe(sfr_wr_strobe), .sfr_wr_addr(sfr_wr_addr),
    .sfr_wr_data(sfr_wr_data));
  srs_core_model i_core (.clk(clk), .req_ready(req_ready), .rsp_ack(rsp_ack), .req_valid(req_valid),
    .req_op(req_op), .req_addr(req_addr), .req_slot(req_slot), .req_ptr_sel(req_ptr_sel),
    .req_wdata(req_wdata), .req_wbit(req_wbit), .req_ret_addr(req_ret_addr));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic test_done();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // slot and pointer select come from the address, bit value from data bit 0
  task automatic op(input srs_op_t o, input logic [7:0] a, input logic [7:0] wd, input logic [15:0] ra);
    i_core.issue(o, a, a[2:0], a[0], wd, wd[0], ra);
    if (i_core.tmo)
    begin
      errors++;
      test_done();
    end
  endtask
  function automatic void add(srs_op_t o, logic [7:0] a, logic [7:0] wd, int k, logic [7:0] e);
    rows.push_back('{o, a, wd, k, e});
  endfunction
  initial
  begin
    nrst = 1'b0;
    add(SRS_OP_RD_DIR, 8'h81, 8'h00, 1, 8'h07);
    add(SRS_OP_WR_DIR, 8'h05, 8'hA5, 0, 8'h00);
    add(SRS_OP_RD_DIR, 8'h05, 8'h00, 1, 8'hA5);
    add(SRS_OP_RD_REG, 8'h05, 8'h00, 1, 8'hA5);
    add(SRS_OP_WR_DIR, 8'h90, 8'h3C, 0, 8'h00);
    add(SRS_OP_WR_DIR, 8'h00, 8'h90, 0, 8'h00);
    add(SRS_OP_WR_IND, 8'h00, 8'hC3, 0, 8'h00);
    add(SRS_OP_RD_DIR, 8'h90, 8'h00, 1, 8'h3C);
    add(SRS_OP_RD_IND, 8'h00, 8'h00, 1, 8'hC3);
    add(SRS_OP_WR_DIR, 8'h01, 8'h20, 0, 8'h00);
    add(SRS_OP_WR_IND, 8'h01, 8'h00, 0, 8'h00);
    add(SRS_OP_WR_BIT, 8'h03, 8'h01, 0, 8'h00);
    add(SRS_OP_RD_DIR, 8'h20, 8'h00, 1, 8'h08);
    add(SRS_OP_RD_BIT, 8'h03, 8'h00, 2, 8'h01);
    add(SRS_OP_RD_BIT, 8'h02, 8'h00, 2, 8'h00);
    add(SRS_OP_WR_DIR, 8'h2F, 8'h00, 0, 8'h00);
    add(SRS_OP_WR_BIT, 8'h7F, 8'h01, 0, 8'h00);
    add(SRS_OP_RD_DIR, 8'h2F, 8'h00, 1, 8'h80);
    add(SRS_OP_WR_BIT, 8'h83, 8'h01, 0, 8'h00);
    add(SRS_OP_RD_DIR, 8'h80, 8'h00, 1, 8'h08);
    add(SRS_OP_WR_DIR, 8'hD0, 8'h10, 0, 8'h00);
    add(SRS_OP_WR_REG, 8'h07, 8'h5A, 0, 8'h00);
    add(SRS_OP_RD_DIR, 8'h17, 8'h00, 1, 8'h5A);
    add(SRS_OP_WR_DIR, 8'hD0, 8'h18, 0, 8'h00);
    add(SRS_OP_WR_DIR, 8'h18, 8'h77, 0, 8'h00);
    add(SRS_OP_RD_REG, 8'h00, 8'h00, 1, 8'h77);
    add(SRS_OP_WR_DIR, 8'hD0, 8'h00, 0, 8'h00);
    add(SRS_OP_PUSH, 8'h00, 8'h11, 0, 8'h00);
    add(SRS_OP_RD_DIR, 8'h81, 8'h00, 1, 8'h08);
    add(SRS_OP_RD_DIR, 8'h08, 8'h00, 1, 8'h11);
    add(SRS_OP_POP, 8'h00, 8'h00, 1, 8'h11);
    add(SRS_OP_RD_DIR, 8'h81, 8'h00, 1, 8'h07);
    add(SRS_OP_NOP, 8'h05, 8'hFF, 0, 8'h00);
    add(SRS_OP_RD_DIR, 8'h05, 8'h00, 1, 8'hA5);
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    foreach (rows[i])
    begin
      i_core.idle = i % 3;
      op(rows[i].o, rows[i].a, rows[i].wd, 16'h00_00);
      `chk(i_core.lat, 1)
      if (rows[i].k == 1) `chk(rsp_rdata, rows[i].e)
      if (rows[i].k == 2) `chk(rsp_rbit, rows[i].e[0])
    end
    op(SRS_OP_WR_DIR, 8'hA8, 8'h5C, 16'h00_00);
    `chk({sfr_wr_addr, sfr_wr_data}, 16'hA8_5C)
    `chk(sfr_wr_strobe, 1'b1)
    op(SRS_OP_WR_DIR, 8'h81, 8'h7F, 16'h00_00);
    op(SRS_OP_CALL, 8'h00, 8'h00, 16'hBE_EF);
    `chk(i_core.lat, 2)
    `chk(stack_top_pointer, 8'h81)
    op(SRS_OP_RD_DIR, 8'h81, 8'h00, 16'h00_00);
    `chk(rsp_rdata, 8'h81)
    op(SRS_OP_WR_DIR, 8'h00, 8'h80, 16'h00_00);
    `chk(sfr_wr_strobe, 1'b0)
    op(SRS_OP_RD_IND, 8'h00, 8'h00, 16'h00_00);
    `chk(rsp_rdata, 8'hEF)
    op(SRS_OP_WR_DIR, 8'h00, 8'h81, 16'h00_00);
    op(SRS_OP_RD_IND, 8'h00, 8'h00, 16'h00_00);
    `chk(rsp_rdata, 8'hBE)
    op(SRS_OP_RET, 8'h00, 8'h00, 16'h00_00);
    `chk(i_core.lat, 2)
    `chk(rsp_ret_addr, 16'hBE_EF)
    `chk(req_ready, 1'b1)
    `chk(stack_top_pointer, 8'h7F)
    op(SRS_OP_WR_DIR, 8'hD0, 8'h08, 16'h00_00);
    `chk(active_bank, 2'h1)
    i_core.rest();
    nrst = 1'b0;
    @(negedge clk);
    `chk(stack_top_pointer, 8'h07)
    `chk(req_ready, 1'b0)
    `chk(active_bank, 2'h0)
    nrst = 1'b1;
    op(SRS_OP_RD_DIR, 8'h81, 8'h00, 16'h00_00);
    `chk(rsp_rdata, 8'h07)
    test_done();
  end
endmodule
